// [src/field_bank_consts.vh]
/*
 field_bank_consts.vh: offsets, field positions and reset values for the
 register field cell bank.
 assumes: included by bare name from design files under src/.
*/
`ifndef FIELD_BANK_CONSTS_VH
`define FIELD_BANK_CONSTS_VH

// register byte offsets, one 32-bit word each
`define OFS_READ_ONLY      6'h00
`define OFS_CLEAR_ON_READ  6'h04
`define OFS_WRITE_ONLY     6'h08
`define OFS_WRITE_ONE_CLR  6'h0c
`define OFS_WRITE_ZERO_CLR 6'h10
`define OFS_LATCH_STATUS   6'h14
`define OFS_SELF_CLEAR     6'h18
`define OFS_IRQ_STATUS     6'h1c
`define OFS_IRQ_CLEAR      6'h20
`define OFS_IRQ_ENABLE     6'h24

// word index of each register, used by the decoder
`define IDX_READ_ONLY      4'h0
`define IDX_CLEAR_ON_READ  4'h1
`define IDX_WRITE_ONLY     4'h2
`define IDX_WRITE_ONE_CLR  4'h3
`define IDX_WRITE_ZERO_CLR 4'h4
`define IDX_LATCH_STATUS   4'h5
`define IDX_SELF_CLEAR     4'h6
`define IDX_IRQ_STATUS     4'h7
`define IDX_IRQ_CLEAR      4'h8
`define IDX_IRQ_ENABLE     4'h9

// field widths and positions
`define FIELD_W            8
`define LATCH_LOW_LSB      0
`define LATCH_HIGH_LSB     8

// interrupt status bit positions
`define IRQ_COR_SET        0
`define IRQ_W1C_SET        1
`define IRQ_W0C_SET        2
`define IRQ_LATCH_LOW      3
`define IRQ_LATCH_HIGH     4
`define IRQ_SC_DONE        5
`define IRQ_UNMAPPED       6
`define IRQ_W              7

// reset values
`define RST_FIELD          8'h00
`define RST_WRITE_ONLY     8'h00
`define RST_W0C            8'h00
`define RST_LATCH_LOW      8'hff
`define RST_LATCH_HIGH     8'h00
`define RST_IRQ            7'h00
`define RST_RDATA          32'h0000_0000

// read data for unspecified and unmapped reads
`define RDATA_UNSPEC       32'h0000_0000
`define RDATA_UNMAPPED     32'hdead_beef

`endif

// [src/field_sync.v]
/*
 field_sync.v: two-flop synchroniser bank for status and event inputs.
 assumes: single clk domain, asynchronous active-low reset.
*/
`timescale 1ns/1ps
module field_sync #(
   parameter W = 8
) (
   clk,
   resetn,
   async_in,
   sync_out
);
   input  wire         clk;
   input  wire         resetn;
   input  wire [W-1:0] async_in;
   output reg  [W-1:0] sync_out;

   reg [W-1:0] meta_q;

   // first stage is read only by the second stage
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_q   <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // field_sync

// [src/field_bank.v]
/*
 field_bank.v: bank of register field cells, one register per access
 attribute, latched-low and latched-high sharing one, reached over avalon-mm with waitrequest, plus sticky
 interrupt status, enable and clear registers.
 assumes: host drives avalon-mm on clk; hw status and event inputs may
 come from other domains and are synchronised here.
*/
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "field_bank_consts.vh"

// What this block does
// RL1: the read-only register returns the live status value and ignores writes.
// RL2: the clear-on-read register returns its value and is cleared by that read; writes do nothing.
// RL3: the write-only register stores writes but reads back an unspecified fixed value.
// RL4: in the write-one-clear register each one written clears that bit, zeros keep it.
// RL5: in the write-zero-clear register each zero written clears that bit, ones keep it.
// RL6: latched-low status bits stay low after their condition falls until a read releases them.
// RL7: latched-high status bits stay high after their condition rises until a read releases them.
// RL8: self-clearing bits set by a write return to zero by themselves next cycle; zero writes do nothing.
// RL9: the host writes zeros to reserved bits; reserved bits read as zero with no guarantee.
// RL10: every register is reachable by the host over the management bus.
// RL11: a write changes only writable fields per their semantics and all state resets defined.
module field_bank (
   clk,
   resetn,
   avs_address,
   avs_read,
   avs_write,
   avs_writedata,
   avs_byteenable,
   avs_readdata,
   avs_waitrequest,
   hw_status,
   hw_cor_event,
   hw_w1c_event,
   hw_w0c_event,
   hw_latch_low_cond,
   hw_latch_high_cond,
   write_only_value,
   self_clear_pulse,
   irq
);
   input  wire                    clk;
   input  wire                    resetn;
   input  wire [5:0]              avs_address;
   input  wire                    avs_read;
   input  wire                    avs_write;
   input  wire [31:0]             avs_writedata;
   input  wire [3:0]              avs_byteenable;
   output reg  [31:0]             avs_readdata;
   output reg                     avs_waitrequest;
   input  wire [`FIELD_W-1:0]     hw_status;
   input  wire [`FIELD_W-1:0]     hw_cor_event;
   input  wire [`FIELD_W-1:0]     hw_w1c_event;
   input  wire [`FIELD_W-1:0]     hw_w0c_event;
   input  wire [`FIELD_W-1:0]     hw_latch_low_cond;
   input  wire [`FIELD_W-1:0]     hw_latch_high_cond;
   output reg  [`FIELD_W-1:0]     write_only_value;
   output reg  [`FIELD_W-1:0]     self_clear_pulse;
   output reg                     irq;

   // synchronised hardware side
   wire [`FIELD_W-1:0] st_s;
   wire [`FIELD_W-1:0] cor_s;
   wire [`FIELD_W-1:0] w1c_s;
   wire [`FIELD_W-1:0] w0c_s;
   wire [`FIELD_W-1:0] ll_n_s;
   wire [`FIELD_W-1:0] ll_s;
   wire [`FIELD_W-1:0] lh_s;

   // latch-low condition crosses inverted so the synchroniser's reset
   // value reads as "condition high" and no false latch follows reset
   assign ll_s = ~ll_n_s;

   field_sync #(.W(6*`FIELD_W)) u_sync (
      .clk      (clk),
      .resetn   (resetn),
      .async_in ({hw_status, hw_cor_event, hw_w1c_event, hw_w0c_event,
                  ~hw_latch_low_cond, hw_latch_high_cond}),
      .sync_out ({st_s, cor_s, w1c_s, w0c_s, ll_n_s, lh_s})
   );

   // field state
   reg  [`FIELD_W-1:0] cor_q;
   reg  [`FIELD_W-1:0] cor_d;
   reg  [`FIELD_W-1:0] w1c_q;
   reg  [`FIELD_W-1:0] w1c_d;
   reg  [`FIELD_W-1:0] w0c_q;
   reg  [`FIELD_W-1:0] w0c_d;
   reg  [`FIELD_W-1:0] ll_q;
   reg  [`FIELD_W-1:0] ll_d;
   reg  [`FIELD_W-1:0] lh_q;
   reg  [`FIELD_W-1:0] lh_d;
   reg  [`FIELD_W-1:0] wo_d;
   reg  [`FIELD_W-1:0] sc_d;
   reg  [`IRQ_W-1:0]   ist_q;
   reg  [`IRQ_W-1:0]   ist_d;
   reg  [`IRQ_W-1:0]   ien_q;
   reg  [`IRQ_W-1:0]   ien_d;
   reg  [31:0]         rdata_d;
   reg                 irq_d;

   // previous synchronised conditions, for latch entry events
   reg  [`FIELD_W-1:0] ll_prev_q;
   reg  [`FIELD_W-1:0] lh_prev_q;

   // bus access is one cycle: waitrequest drops on the cycle after request
   wire       req   = (avs_read | avs_write) & avs_waitrequest;
   wire       wr    = avs_write & req;
   wire       rd    = avs_read & req;
   wire [3:0] index = avs_address[5:2];
   wire       be0   = avs_byteenable[0];
   wire       be1   = avs_byteenable[1];
   wire [7:0] wd0   = avs_writedata[7:0];

   // 1 when the word index matches the register index, keeps the decode short at each site
   function hit;
      input [3:0] a;
      input [3:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // map an index to known register, unmapped otherwise
   function mapped;
      input [3:0] a;
      begin
         mapped = (a <= `IDX_IRQ_ENABLE);
      end
   endfunction

   // next state of every field; hardware set wins over software clear
   always @* begin
      cor_d   = cor_q | cor_s;                              // [RL2]
      w1c_d   = w1c_q;
      w0c_d   = w0c_q;
      ll_d    = ll_q & ll_s;                                // [RL6]
      lh_d    = lh_q | lh_s;                                // [RL7]
      wo_d    = write_only_value;
      sc_d    = {`FIELD_W{1'b0}};                           // [RL8]
      ist_d   = ist_q;
      ien_d   = ien_q;
      rdata_d = `RST_RDATA;
      // write side: only writable fields move [RL11]
      if (wr && be0) begin
         if (hit(index, `IDX_WRITE_ONLY))
            wo_d = wd0;                                     // [RL3]
         if (hit(index, `IDX_WRITE_ONE_CLR))
            w1c_d = w1c_q & ~wd0;                           // [RL4]
         if (hit(index, `IDX_WRITE_ZERO_CLR))
            w0c_d = w0c_q & wd0;                            // [RL5]
         if (hit(index, `IDX_SELF_CLEAR))
            sc_d = wd0;                                     // [RL8]
         if (hit(index, `IDX_IRQ_CLEAR))
            ist_d = ist_q & ~wd0[`IRQ_W-1:0];
         if (hit(index, `IDX_IRQ_ENABLE))
            ien_d = wd0[`IRQ_W-1:0];
      end
      // read side [RL10]; reserved bits read as zero [RL9]
      if (rd) begin
         case (index)
            `IDX_READ_ONLY:      rdata_d = {24'h000000, st_s};  // [RL1]
            `IDX_CLEAR_ON_READ: begin
               rdata_d = {24'h000000, cor_q};
               cor_d   = cor_s;                             // [RL2]
            end
            `IDX_WRITE_ONLY:     rdata_d = `RDATA_UNSPEC;   // [RL3]
            `IDX_WRITE_ONE_CLR:  rdata_d = {24'h000000, w1c_q};
            `IDX_WRITE_ZERO_CLR: rdata_d = {24'h000000, w0c_q};
            `IDX_LATCH_STATUS: begin
               rdata_d = {16'h0000, lh_q, ll_q};
               ll_d    = ll_s;                              // [RL6]
               lh_d    = lh_s;                              // [RL7]
            end
            `IDX_SELF_CLEAR:     rdata_d = {24'h000000, self_clear_pulse};
            `IDX_IRQ_STATUS:     rdata_d = {25'h0000000, ist_q};
            `IDX_IRQ_ENABLE:     rdata_d = {25'h0000000, ien_q};
            `IDX_IRQ_CLEAR:      rdata_d = `RDATA_UNSPEC;
            default:             rdata_d = `RDATA_UNMAPPED;
         endcase
      end
      // hardware sets the w1c/w0c fields after any clear, so it wins
      w1c_d = w1c_d | w1c_s;
      w0c_d = w0c_d | w0c_s;
      // sticky event bits are set last so a set beats a clear
      if (|cor_s)
         ist_d[`IRQ_COR_SET] = 1'b1;
      if (|w1c_s)
         ist_d[`IRQ_W1C_SET] = 1'b1;
      if (|w0c_s)
         ist_d[`IRQ_W0C_SET] = 1'b1;
      if (|(ll_prev_q & ~ll_s))
         ist_d[`IRQ_LATCH_LOW] = 1'b1;
      if (|(~lh_prev_q & lh_s))
         ist_d[`IRQ_LATCH_HIGH] = 1'b1;
      if (|self_clear_pulse)
         ist_d[`IRQ_SC_DONE] = 1'b1;
      if (req && !mapped(index))
         ist_d[`IRQ_UNMAPPED] = 1'b1;
      irq_d = |(ist_d & ien_d);
   end

   // all state takes defined values at reset [RL11]
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cor_q            <= `RST_FIELD;
         w1c_q            <= `RST_FIELD;
         w0c_q            <= `RST_W0C;
         ll_q             <= `RST_LATCH_LOW;
         lh_q             <= `RST_LATCH_HIGH;
         ll_prev_q        <= `RST_LATCH_LOW;
         lh_prev_q        <= `RST_LATCH_HIGH;
         write_only_value <= `RST_WRITE_ONLY;
         self_clear_pulse <= `RST_FIELD;
         ist_q            <= `RST_IRQ;
         ien_q            <= `RST_IRQ;
         irq              <= 1'b0;
         avs_readdata     <= `RST_RDATA;
         avs_waitrequest  <= 1'b1;
      end else begin
         cor_q            <= cor_d;
         w1c_q            <= w1c_d;
         w0c_q            <= w0c_d;
         ll_q             <= ll_d;
         lh_q             <= lh_d;
         ll_prev_q        <= ll_s;
         lh_prev_q        <= lh_s;
         write_only_value <= wo_d;
         self_clear_pulse <= sc_d;                          // [RL8]
         ist_q            <= ist_d;
         ien_q            <= ien_d;
         irq              <= irq_d;
         if (req)
            avs_readdata  <= rdata_d;
         // drop waitrequest for one cycle per request
         avs_waitrequest  <= ~req;
      end
   end
endmodule // field_bank

// [dv/host_model.sv]
/*
 host_model.sv: avalon-mm host that drives the register bus of the bank.
 assumes: slave drops waitrequest for one cycle to answer each request.
*/
`timescale 1ns/1ps
module host_model (
   input  wire logic        clk,
   output logic [5:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata,
   output logic [3:0]       avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   // idle bus at time zero
   initial begin
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'h0;
   end

   // one transfer; released address and data lines show the inverse so stale data shows
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [7:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_read <= ~w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d}; // reserved bits zero
      avs_byteenable <= 4'h1;
      // no cycle count assumed; the bench watchdog ends a hang
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_address <= ~a;
      avs_writedata <= ~{24'h00_0000, d};
   endtask
endmodule // host_model

// [dv/field_bank_checker.sv]
/*
 field_bank_checker.sv: bus and field assertions for field_bank.
 assumes: bound to field_bank; one clock, async active-low reset.
*/
`timescale 1ns/1ps
`include "field_bank_consts.vh"
module field_bank_checker (
   input wire                clk,
   input wire                resetn,
   input wire [5:0]          avs_address,
   input wire                avs_read,
   input wire                avs_write,
   input wire [31:0]         avs_writedata,
   input wire [3:0]          avs_byteenable,
   input wire [31:0]         avs_readdata,
   input wire                avs_waitrequest,
   input wire [`FIELD_W-1:0] write_only_value,
   input wire [`FIELD_W-1:0] self_clear_pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // request taken on this edge
   wire take = (avs_read | avs_write) & avs_waitrequest;
   wire wo_wr = take & avs_write & (avs_address == `OFS_WRITE_ONLY);
   wire sc_wr = take & avs_write & (avs_address == `OFS_SELF_CLEAR);

   chk_answer_next: assert property (take |=> !avs_waitrequest)
      else $error("request not answered next cycle");
   chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_read_hold: assert property (!take |=> $stable(avs_readdata))
      else $error("read data moved without a request");
   chk_wo_capture: assert property ((wo_wr && avs_byteenable[0])
      |=> write_only_value == avs_writedata[7:0])
      else $error("write-only value not captured");
   chk_wo_hold: assert property ($changed(write_only_value)
      |-> $past(wo_wr))
      else $error("write-only value moved without a write");
   chk_sc_set: assert property ((sc_wr && avs_byteenable[0])
      |=> self_clear_pulse == avs_writedata[7:0])
      else $error("self-clear pulse wrong after write");
   chk_sc_drop: assert property ((self_clear_pulse != 8'h00)
      |=> (self_clear_pulse == 8'h00))
      else $error("self-clear bits did not drop");
   chk_sc_cause: assert property ((self_clear_pulse != 8'h00)
      |-> $past(sc_wr))
      else $error("self-clear pulse without a write");
endmodule // field_bank_checker

bind field_bank field_bank_checker u_field_bank_checker (
   .clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_readdata, .avs_waitrequest, .write_only_value,
   .self_clear_pulse);

// [dv/field_bank_tb_top.sv]
/*
 field_bank_tb_top.sv: self-checking bench for field_bank.
 assumes: host_model speaks the bus; hw inputs driven here at 250 MHz.
*/
`timescale 1ns/1ps
`include "field_bank_consts.vh"
module field_bank_tb_top;
   typedef struct {logic w; logic [5:0] a; logic [7:0] d, e;} row_t;
   logic        clk, resetn, rd_s, wr_s, wait_s, irq;
   logic [5:0]  addr;
   logic [31:0] wdat, rdat, q;
   logic [3:0]  be;
   logic [7:0]  st, cor, w1c, w0c, llc, lhc, wov, scp;
   int          err_total, checks_done;
   row_t        rows [8];

   field_bank u_field_bank (.clk, .resetn, .avs_address(addr),
      .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdat),
      .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_s),
      .hw_status(st), .hw_cor_event(cor), .hw_w1c_event(w1c),
      .hw_w0c_event(w0c), .hw_latch_low_cond(llc),
      .hw_latch_high_cond(lhc), .write_only_value(wov),
      .self_clear_pulse(scp), .irq);
   host_model u_host_model (.clk, .avs_address(addr), .avs_read(rd_s),
      .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be),
      .avs_readdata(rdat), .avs_waitrequest(wait_s));

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      cmp8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic rd(input logic [5:0] a);
      u_host_model.bus(1'b0, a, 8'h00, q);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      u_host_model.bus(1'b1, a, d, q);
   endtask
   // events pass a two-flop synchroniser, so give them room
   task automatic settle;
      repeat (6) @(posedge clk);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (4000) @(posedge clk);
      err_total++;
      close_out();
   end

   initial begin
      {resetn, cor, w1c, w0c, lhc} = '0;
      st = 8'h5a;
      llc = 8'hff;
      err_total = 0;
      checks_done = 0;
      rows = '{'{1, `OFS_READ_ONLY, 8'hff, 0}, '{0, `OFS_READ_ONLY, 0, 8'h5a},
         '{1, `OFS_WRITE_ONLY, 8'h3c, 0}, '{1, `OFS_WRITE_ONE_CLR, 8'hff, 0},
         '{0, `OFS_WRITE_ONE_CLR, 0, 0}, '{0, `OFS_WRITE_ZERO_CLR, 0, 0},
         '{0, `OFS_LATCH_STATUS, 0, 8'hff}, '{0, `OFS_IRQ_STATUS, 0, 0}};
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      foreach (rows[i]) begin
         u_host_model.bus(rows[i].w, rows[i].a, rows[i].d, q);
         if (!rows[i].w) cmp8(q[7:0], rows[i].e);
      end
      cmp8(wov, 8'h3c);
      $display("table done");
      @(posedge clk) {cor, w1c, w0c, llc, lhc} <= 40'h81_f0_0f_fe_02;
      settle();
      @(posedge clk) {cor, w1c, w0c, llc, lhc} <= 40'h00_00_00_ff_00;
      settle();
      wr(`OFS_CLEAR_ON_READ, 8'h00);
      rd(`OFS_CLEAR_ON_READ);
      cmp8(q[7:0], 8'h81);
      rd(`OFS_CLEAR_ON_READ);
      cmp8(q[7:0], 8'h00);
      wr(`OFS_WRITE_ONE_CLR, 8'h30);
      rd(`OFS_WRITE_ONE_CLR);
      cmp8(q[7:0], 8'hc0);
      wr(`OFS_WRITE_ZERO_CLR, 8'h03);
      rd(`OFS_WRITE_ZERO_CLR);
      cmp8(q[7:0], 8'h03);
      rd(`OFS_LATCH_STATUS);
      cmp8(q[7:0], 8'hfe);
      cmp8(q[15:8], 8'h02);
      rd(`OFS_LATCH_STATUS);
      cmp8(q[7:0], 8'hff);
      cmp8(q[15:8], 8'h00);
      wr(`OFS_SELF_CLEAR, 8'h05);
      wr(`OFS_SELF_CLEAR, 8'h00);
      cmp8(scp, 8'h00);
      rd(`OFS_SELF_CLEAR);
      cmp8(q[7:0], 8'h00);
      $display("field tests done");
      wr(`OFS_IRQ_CLEAR, 8'h7f);
      wr(`OFS_IRQ_ENABLE, 8'h01);
      @(posedge clk) cor <= 8'h01;
      settle();
      cor <= 8'h00;
      cmp1(irq, 1'b1);
      // let the event leave the synchroniser, or the set beats the clear
      settle();
      wr(`OFS_IRQ_CLEAR, 8'h01);
      settle();
      cmp1(irq, 1'b0);
      wr(`OFS_IRQ_ENABLE, 8'h00);
      cor <= 8'h01;
      settle();
      cor <= 8'h00;
      cmp1(irq, 1'b0);
      rd(`OFS_IRQ_STATUS);
      cmp1(q[0], 1'b1);
      rd(6'h28);
      cmp8(q[7:0], 8'hef);
      cmp8(q[31:24], 8'hde);
      rd(`OFS_IRQ_STATUS);
      cmp1(q[`IRQ_UNMAPPED], 1'b1);
      resetn <= 1'b0;
      @(posedge clk);
      cmp8(wov, 8'h00);
      cmp1(irq, 1'b0);
      resetn <= 1'b1;
      settle();
      rd(`OFS_LATCH_STATUS);
      cmp8(q[7:0], 8'hff);
      rd(`OFS_READ_ONLY);
      cmp8(q[7:0], 8'h5a);
      $display("irq and reset done");
      close_out();
   end
endmodule // field_bank_tb_top
